// *** hdl/sfr_core_params.svh ***
// Constants for the special-function register core
`ifndef SFR_CORE_PARAMS_SVH
`define SFR_CORE_PARAMS_SVH
// Sector 0 addresses of the special registers
`define ADDR_PORT_ZERO 8'h00
`define ADDR_PTR_ZERO 8'h01
`define ADDR_PORT_ONE 8'h02
`define ADDR_PTR_ONE_LOW 8'h03
`define ADDR_PTR_ONE_HIGH 8'h04
`define ADDR_WORK 8'h05
`define ADDR_PC_LOW 8'h06
`define ADDR_TBL_LOW 8'h07
`define ADDR_TBL_RESULT 8'h08
`define ADDR_TBL_HIGH 8'h09
`define ADDR_STATUS 8'h0A
`define ADDR_PORT_TWO 8'h0B
`define ADDR_PTR_TWO_LOW 8'h0C
`define ADDR_PTR_TWO_HIGH 8'h0D
// Status field positions
`define ST_CARRY 0
`define ST_NIBBLE 1
`define ST_ZERO 2
`define ST_SIGNED 3
`define ST_SLEEP 4
`define ST_WDOG 5
`define ST_CHAIN 6
`define ST_SCMP 7
// Reset values
`define RST_BYTE 8'h00
`define RST_STATUS 8'h00
`define READ_NONE 8'h00
`endif

// *** hdl/sfr_core_pkg.sv ***
// Types for the special-function register core
package sfr_core_pkg;
  typedef enum logic [3:0] {
    OP_NONE, OP_ADD, OP_ADC, OP_SUB, OP_SBC, OP_AND, OP_OR, OP_XOR,
    OP_INC, OP_DEC, OP_RLC, OP_RRC, OP_MOV_TO_WORK, OP_MOV_FROM_WORK, OP_TABLE_READ
  } alu_op_e;
  typedef enum logic [1:0] {
    ADDR_DIRECT, ADDR_EXTENDED
  } addr_mode_e;
  typedef struct packed {
    logic valid;
    alu_op_e op;
    addr_mode_e mode;
    logic [10:0] addr;
    logic [7:0] imm;
    logic use_imm;
    logic dest_mem;
  } instr_s;
  typedef struct packed {
    logic req;
    logic wr;
    logic [10:0] addr;
    logic [7:0] wdata;
  } mem_req_s;
  typedef struct packed {
    logic [15:0] table_addr;
    logic table_req;
    logic pc_load;
    logic [7:0] pc_low;
    logic stall;
  } prog_req_s;
  typedef enum logic [1:0] {
    ST_RUN, ST_DUMMY
  } seq_e;
endpackage : sfr_core_pkg

// *** hdl/sfr_core.sv ***
// Special-function register core: indirect ports, pointers, work register and flags
`timescale 1ns/1ps
`default_nettype none
`include "sfr_core_params.svh"

// Behaviour
// - Indirect ports access memory through their pointer
// - Port zero reaches sector zero; others anywhere
// - Port itself reads zero, write ignored
// - Five pointer registers, ordinary read/write/modify
// - High pointer byte selects sector, low offset
// - Extended addresses reach any sector
// - Register transfers pass through work register
// - Low-byte write jumps within current page
// - Low-byte load adds one dummy cycle
// - Table read: high byte to result register
// - Status writes leave watchdog and sleep flags
// - Carry from add, no-borrow, rotate
// - Nibble carry from low nibble or no-borrow
// - Zero flag set on zero result
// - Signed overflow is carry-in xor carry-out
// - Sleep flag: refresh clears, halt sets
// - Watchdog flag: refresh/halt clear, timeout sets
// - Signed compare is overflow xor result msb
// - Status never saved automatically
// - Unused locations read zero
// - Extended addresses carry eleven bits
module sfr_core import sfr_core_pkg::*; #(
  parameter int SECTOR_BITS = 3
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Instruction stream
  input wire instr_s instr,
  input wire logic halt_exec,
  input wire logic refresh_exec,
  input wire logic watchdog_timeout,
  // Data memory
  output mem_req_s mem_req,
  input wire logic [7:0] mem_rdata,
  // Program memory
  output prog_req_s prog_req,
  input wire logic [15:0] table_word,
  // Visible state
  output logic [7:0] work_out,
  output logic [7:0] status_flags_out
);

  // ----------------------------------------------------------------
  // Parameter check and reset release
  // ----------------------------------------------------------------
  // Sector field is three bits wide; more would need a wider address
  if (SECTOR_BITS < 1 || SECTOR_BITS > 3) begin : g_sector_check
    $error("SECTOR_BITS must lie between 1 and 3");
  end

  logic rst_meta_b;
  logic rst_sync_b;
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_b <= 1'b0;
      rst_sync_b <= 1'b0;
    end else begin
      rst_meta_b <= 1'b1;
      rst_sync_b <= rst_meta_b;
    end
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] ptr_zero;
    logic [7:0] ptr_one_low;
    logic [7:0] ptr_one_high;
    logic [7:0] ptr_two_low;
    logic [7:0] ptr_two_high;
    logic [7:0] work;
    logic [7:0] tbl_low;
    logic [7:0] tbl_high;
    logic [7:0] tbl_result;
    logic [7:0] status;
    seq_e seq;
    mem_req_s mem;
    prog_req_s prog;
  } state_s;

  state_s state_reg;
  state_s state_next;

  // ----------------------------------------------------------------
  // Address resolution
  // ----------------------------------------------------------------
  logic [10:0] eff_addr;
  logic is_port;
  logic is_sfr;
  always_comb begin
    eff_addr = instr.addr;
    if (instr.mode == ADDR_EXTENDED) begin
      eff_addr = {instr.addr[10:8] & 3'((1 << SECTOR_BITS) - 1), instr.addr[7:0]};
    end else if (instr.addr[7:0] == `ADDR_PORT_ZERO) begin
      eff_addr = {3'b000, state_reg.ptr_zero};
    end else if (instr.addr[7:0] == `ADDR_PORT_ONE) begin
      eff_addr = {state_reg.ptr_one_high[2:0] & 3'((1 << SECTOR_BITS) - 1),
                  state_reg.ptr_one_low};
    end else if (instr.addr[7:0] == `ADDR_PORT_TWO) begin
      eff_addr = {state_reg.ptr_two_high[2:0] & 3'((1 << SECTOR_BITS) - 1),
                  state_reg.ptr_two_low};
    end else begin
      eff_addr = {3'b000, instr.addr[7:0]};
    end
    // A pointer aimed back at a port finds no storage there
    is_port = (eff_addr[10:8] == 3'b000) && (eff_addr[7:0] == `ADDR_PORT_ZERO ||
              eff_addr[7:0] == `ADDR_PORT_ONE || eff_addr[7:0] == `ADDR_PORT_TWO);
    is_sfr = (eff_addr[10:8] == 3'b000) && (eff_addr[7:0] <= `ADDR_PTR_TWO_HIGH);
  end

  // Operand read mux; memory data is combinational from the array
  logic [7:0] operand;
  always_comb begin
    operand = `READ_NONE;
    if (instr.use_imm) begin
      operand = instr.imm;
    end else if (is_port) begin
      operand = `READ_NONE;
    end else if (is_sfr) begin
      unique case (eff_addr[7:0])
        `ADDR_PTR_ZERO: operand = state_reg.ptr_zero;
        `ADDR_PTR_ONE_LOW: operand = state_reg.ptr_one_low;
        `ADDR_PTR_ONE_HIGH: operand = state_reg.ptr_one_high;
        `ADDR_WORK: operand = state_reg.work;
        `ADDR_PC_LOW: operand = state_reg.prog.pc_low;
        `ADDR_TBL_LOW: operand = state_reg.tbl_low;
        `ADDR_TBL_RESULT: operand = state_reg.tbl_result;
        `ADDR_TBL_HIGH: operand = state_reg.tbl_high;
        `ADDR_STATUS: operand = state_reg.status;
        `ADDR_PTR_TWO_LOW: operand = state_reg.ptr_two_low;
        `ADDR_PTR_TWO_HIGH: operand = state_reg.ptr_two_high;
        default: operand = `READ_NONE;
      endcase
    end else begin
      operand = mem_rdata;
    end
  end

  // ----------------------------------------------------------------
  // Arithmetic
  // ----------------------------------------------------------------
  logic [8:0] sum;
  logic [4:0] nib;
  logic [7:0] low7;
  logic [7:0] result;
  logic [7:0] b_in;
  logic cin;
  logic arith;
  logic logic_op;
  always_comb begin
    b_in = operand;
    cin = 1'b0;
    arith = 1'b1;
    logic_op = 1'b0;
    result = `READ_NONE;
    unique case (instr.op)
      OP_SUB: begin b_in = ~operand; cin = 1'b1; end
      OP_SBC: begin b_in = ~operand; cin = state_reg.status[`ST_CARRY]; end
      OP_ADC: cin = state_reg.status[`ST_CARRY];
      OP_ADD: cin = 1'b0;
      default: arith = 1'b0;
    endcase
    // Subtract as add of complement, so carry means no borrow
    sum = {1'b0, state_reg.work} + {1'b0, b_in} + {8'h00, cin};
    nib = {1'b0, state_reg.work[3:0]} + {1'b0, b_in[3:0]} + {4'h0, cin};
    low7 = {1'b0, state_reg.work[6:0]} + {1'b0, b_in[6:0]} + {7'h00, cin};
    unique case (instr.op)
      OP_ADD, OP_ADC, OP_SUB, OP_SBC: result = sum[7:0];
      OP_AND: begin result = state_reg.work & operand; logic_op = 1'b1; end
      OP_OR: begin result = state_reg.work | operand; logic_op = 1'b1; end
      OP_XOR: begin result = state_reg.work ^ operand; logic_op = 1'b1; end
      OP_INC: begin result = operand + 8'h01; logic_op = 1'b1; end
      OP_DEC: begin result = operand - 8'h01; logic_op = 1'b1; end
      OP_RLC: result = {operand[6:0], state_reg.status[`ST_CARRY]};
      OP_RRC: result = {state_reg.status[`ST_CARRY], operand[7:1]};
      OP_MOV_TO_WORK: result = operand;
      OP_MOV_FROM_WORK: result = state_reg.work;
      default: result = operand;
    endcase
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  logic [7:0] st;
  logic do_write;
  always_comb begin
    state_next = state_reg;
    state_next.mem.req = 1'b0;
    state_next.mem.wr = 1'b0;
    state_next.prog.table_req = 1'b0;
    state_next.prog.pc_load = 1'b0;
    state_next.prog.stall = 1'b0;
    st = state_reg.status;
    do_write = 1'b0;
    if (state_reg.seq == ST_DUMMY) begin
      state_next.seq = ST_RUN;
    end else if (instr.valid) begin
      // Flags not named by the op keep their value
      if (arith) begin
        st[`ST_CARRY] = sum[8];
        st[`ST_NIBBLE] = nib[4];
        st[`ST_SIGNED] = low7[7] ^ sum[8];
        st[`ST_ZERO] = (result == 8'h00);
        st[`ST_SCMP] = st[`ST_SIGNED] ^ result[7];
        if (instr.op == OP_SUB) begin
          st[`ST_CHAIN] = st[`ST_ZERO];
        end else if (instr.op == OP_SBC) begin
          st[`ST_CHAIN] = st[`ST_ZERO] & state_reg.status[`ST_CHAIN];
        end
      end else if (logic_op) begin
        st[`ST_ZERO] = (result == 8'h00);
      end else if (instr.op == OP_RLC) begin
        st[`ST_CARRY] = operand[7];
      end else if (instr.op == OP_RRC) begin
        st[`ST_CARRY] = operand[0];
      end
      // Work register is the only path between two locations
      if (instr.op == OP_MOV_FROM_WORK || (instr.dest_mem && instr.op != OP_MOV_TO_WORK &&
          instr.op != OP_TABLE_READ)) begin
        do_write = 1'b1;
      end else if (instr.op == OP_TABLE_READ) begin
        state_next.prog.table_addr = {state_reg.tbl_high, state_reg.tbl_low};
        state_next.prog.table_req = 1'b1;
        state_next.tbl_result = table_word[15:8];
        state_next.mem.req = 1'b1;
        state_next.mem.wr = 1'b1;
        state_next.mem.addr = eff_addr;
        state_next.mem.wdata = table_word[7:0];
      end else if (instr.op != OP_NONE) begin
        state_next.work = result;
      end
      if (do_write && !is_port && is_sfr) begin
        unique case (eff_addr[7:0])
          `ADDR_PTR_ZERO: state_next.ptr_zero = result;
          `ADDR_PTR_ONE_LOW: state_next.ptr_one_low = result;
          `ADDR_PTR_ONE_HIGH: state_next.ptr_one_high = result;
          `ADDR_PTR_TWO_LOW: state_next.ptr_two_low = result;
          `ADDR_PTR_TWO_HIGH: state_next.ptr_two_high = result;
          `ADDR_WORK: state_next.work = result;
          `ADDR_TBL_LOW: state_next.tbl_low = result;
          `ADDR_TBL_HIGH: state_next.tbl_high = result;
          `ADDR_TBL_RESULT: state_next.tbl_result = result;
          `ADDR_STATUS: begin
            st = {result[7:6], state_reg.status[`ST_WDOG], state_reg.status[`ST_SLEEP],
                  result[3:0]};
          end
          `ADDR_PC_LOW: begin
            state_next.prog.pc_low = result;
            state_next.prog.pc_load = 1'b1;
            state_next.prog.stall = 1'b1;
            state_next.seq = ST_DUMMY;
          end
          default: state_next.mem.req = 1'b0;
        endcase
      end else if (do_write && !is_port) begin
        state_next.mem.req = 1'b1;
        state_next.mem.wr = 1'b1;
        state_next.mem.addr = eff_addr;
        state_next.mem.wdata = result;
      end
    end
    // System flags; a timeout wins over a same-cycle clear
    if (refresh_exec) begin
      st[`ST_SLEEP] = 1'b0;
      st[`ST_WDOG] = 1'b0;
    end
    if (halt_exec) begin
      st[`ST_SLEEP] = 1'b1;
      st[`ST_WDOG] = 1'b0;
    end
    if (watchdog_timeout) begin
      st[`ST_WDOG] = 1'b1;
    end
    // Nothing is pushed on call or interrupt entry
    state_next.status = st;
  end

  always_ff @(posedge sys_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign mem_req = state_reg.mem;
  assign prog_req = state_reg.prog;
  assign work_out = state_reg.work;
  assign status_flags_out = state_reg.status;

endmodule : sfr_core
`default_nettype wire

// *** tb/sfr_core_props.sv ***
// Assertions for the special-function register core
`timescale 1ns/1ps
`default_nettype none
module sfr_core_props import sfr_core_pkg::*; #(
  parameter int SECTOR_BITS = 3
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Stimulus
  input wire instr_s instr,
  input wire logic halt_exec,
  input wire logic refresh_exec,
  input wire logic watchdog_timeout,
  // Results
  input wire mem_req_s mem_req,
  input wire prog_req_s prog_req,
  input wire logic [7:0] work_out,
  input wire logic [7:0] status_flags_out
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  a_halt_sleep: assert property (
    halt_exec && !refresh_exec && !watchdog_timeout |=> status_flags_out[5:4] == 2'b01)
    else $error("halt flags wrong");
  a_refresh_clears: assert property (
    refresh_exec && !halt_exec && !watchdog_timeout |=> status_flags_out[5:4] == 2'b00)
    else $error("refresh flags wrong");
  a_timeout_sets: assert property (watchdog_timeout |=> status_flags_out[5])
    else $error("timeout flag not set");
  a_sleep_holds: assert property (
    !halt_exec && !refresh_exec |=> $stable(status_flags_out[4]))
    else $error("sleep flag moved");
  a_expiry_holds: assert property (
    !halt_exec && !refresh_exec && !watchdog_timeout |=> $stable(status_flags_out[5]))
    else $error("expiry flag moved");
  a_dummy_ignored: assert property (
    prog_req.pc_load |-> prog_req.stall ##1 ($stable(work_out) && !prog_req.pc_load))
    else $error("dummy cycle not kept");
  a_port_zero_sector: assert property (
    mem_req.req && $past(instr.valid) && $past(instr.mode) == ADDR_DIRECT
    && $past(instr.addr[7:0]) == 8'h00 |-> mem_req.addr[10:8] == 3'h0)
    else $error("port zero left sector zero");
  a_extended_addr: assert property (
    mem_req.req && $past(instr.valid) && $past(instr.mode) == ADDR_EXTENDED
    && $past(instr.addr[10:8]) != 3'h0 |-> mem_req.addr == $past(instr.addr))
    else $error("extended address wrong");
  a_table_cause: assert property (
    prog_req.table_req |-> $past(instr.valid) && $past(instr.op) == OP_TABLE_READ)
    else $error("stray table request");
endmodule : sfr_core_props
bind sfr_core sfr_core_props #(.SECTOR_BITS(SECTOR_BITS)) sfr_core_props_inst (
  .sys_clk(sys_clk), .rst_b(rst_b), .instr(instr), .halt_exec(halt_exec),
  .refresh_exec(refresh_exec), .watchdog_timeout(watchdog_timeout), .mem_req(mem_req),
  .prog_req(prog_req), .work_out(work_out), .status_flags_out(status_flags_out));
`default_nettype wire

// *** tb/mcu_indirect_addressing_and_flags_tb_top.sv ***
// Self-checking bench for the special-function register core
`timescale 1ns/1ps
`default_nettype none
`include "sfr_core_params.svh"
module mcu_indirect_addressing_and_flags_tb_top import sfr_core_pkg::*;;
  typedef struct {int due; int what; logic [31:0] val;} note_s;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [2:0] ev = 3'b000;
  logic [7:0] mem_rdata = 8'h5A;
  logic [15:0] table_word = 16'hABCD;
  logic [7:0] work_out, status_flags_out, exp_work = 8'h00, exp_st = 8'h00;
  logic [31:0] r;
  instr_s instr = '0;
  mem_req_s mem_req;
  prog_req_s prog_req;
  int errors = 0, tests_run = 0, seed = 76298, ncyc = 0;
  note_s notes[$];
  sfr_core sfr_core_inst (.sys_clk(sys_clk), .rst_b(rst_b), .instr(instr),
    .halt_exec(ev[0]), .refresh_exec(ev[1]), .watchdog_timeout(ev[2]), .mem_req(mem_req),
    .mem_rdata(mem_rdata), .prog_req(prog_req), .table_word(table_word),
    .work_out(work_out), .status_flags_out(status_flags_out));
  always #12.5 sys_clk = ~sys_clk;
  task automatic check(input logic [31:0] got, input logic [31:0] want);
    tests_run++;
    if (got !== want) begin
      errors++;
      $display("FAIL %0t: saw %h, wanted %h", $time, got, want);
    end
  endtask : check
  task automatic note_result(input int what, input logic [31:0] val);
    notes.push_back('{ncyc + 2, what, val});
  endtask : note_result
  // Results show at the taking edge, one cycle after issue, so check on the falling edge after it
  always @(negedge sys_clk) begin
    ncyc++;
    while (notes.size() > 0 && notes[0].due == ncyc) begin
      case (notes[0].what)
        0: check({24'h0, work_out}, notes[0].val);
        1: check({24'h0, status_flags_out}, notes[0].val);
        2: check({11'h0, mem_req.req, mem_req.wr, mem_req.addr, mem_req.wdata},
                 notes[0].val);
        4: check({15'h0, prog_req.table_req, prog_req.table_addr},
                 notes[0].val);
        default: check({22'h0, prog_req.pc_load, prog_req.stall, prog_req.pc_low},
                       notes[0].val);
      endcase
      void'(notes.pop_front());
    end
  end
  task automatic issue(input alu_op_e op, input addr_mode_e md, input logic [10:0] a,
      input logic [7:0] im, input logic ui, input logic dm);
    @(posedge sys_clk);
    instr <= '{1'b1, op, md, a, im, ui, dm};
  endtask : issue
  task automatic ld(input logic [7:0] v);
    issue(OP_MOV_TO_WORK, ADDR_DIRECT, 11'h000, v, 1'b1, 1'b0);
    exp_work = v;
  endtask : ld
  task automatic st(input logic [7:0] a);
    issue(OP_MOV_FROM_WORK, ADDR_DIRECT, {3'h0, a}, 8'h00, 1'b0, 1'b1);
  endtask : st
  // Also ends any instruction stream, since valid is a level
  task automatic pulse(input logic [2:0] e, input logic [7:0] keep, input logic [7:0] set);
    @(posedge sys_clk);
    instr.valid <= 1'b0;
    ev <= e;
    exp_st = (exp_st & keep) | set;
    note_result(1, {24'h0, exp_st});
    @(posedge sys_clk);
    ev <= 3'b000;
  endtask : pulse
  task automatic arith(input logic sub, input logic [7:0] b);
    logic [8:0] s;
    logic [4:0] n;
    logic [7:0] l, bb, q;
    logic ov;
    bb = sub ? ~b : b;
    s = {1'b0, exp_work} + {1'b0, bb} + {8'h00, sub};
    n = {1'b0, exp_work[3:0]} + {1'b0, bb[3:0]} + {4'h0, sub};
    l = {1'b0, exp_work[6:0]} + {1'b0, bb[6:0]} + {7'h00, sub};
    q = s[7:0];
    ov = l[7] ^ s[8];
    exp_st = {ov ^ q[7], sub ? q == 8'h00 : exp_st[6], exp_st[5:4], ov, q == 8'h00, n[4], s[8]};
    exp_work = q;
    issue(sub ? OP_SUB : OP_ADD, ADDR_DIRECT, 11'h000, b, 1'b1, 1'b0);
    note_result(0, {24'h0, q});
    note_result(1, {24'h0, exp_st});
  endtask : arith
  task automatic tally_and_finish();
    // A note never reached means a result that never showed
    if (notes.size() != 0) begin
      errors++;
    end
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    #(25 * 3000);
    errors++;
    tally_and_finish();
  end
  initial begin
    repeat (10) @(posedge sys_clk);
    rst_b <= 1'b1;
    @(posedge sys_clk);
    note_result(1, 32'h0000_0000);
    ld(8'h7F);
    arith(1'b0, 8'h01);
    arith(1'b0, 8'h80);
    arith(1'b1, 8'h01);
    repeat (24) begin
      r = $random(seed);
      arith(r[8], r[7:0]);
    end
    pulse(3'b001, 8'hCF, 8'h10);
    ld(8'hFF);
    st(`ADDR_STATUS);
    exp_st = 8'hCF | (exp_st & 8'h30);
    note_result(1, {24'h0, exp_st});
    pulse(3'b100, 8'hFF, 8'h20);
    pulse(3'b010, 8'hCF, 8'h00);
    ld(8'h01);
    st(`ADDR_PTR_ONE_HIGH);
    ld(8'h40);
    st(`ADDR_PTR_ONE_LOW);
    st(`ADDR_PORT_ONE);
    note_result(2, {11'h0, 2'b11, 11'h140, 8'h40});
    issue(OP_INC, ADDR_DIRECT, {3'h0, `ADDR_PTR_ONE_LOW}, 8'h00, 1'b0, 1'b1);
    st(`ADDR_PORT_ONE);
    note_result(2, {11'h0, 2'b11, 11'h141, 8'h40});
    ld(8'h85);
    st(`ADDR_PTR_ZERO);
    st(`ADDR_PORT_ZERO);
    note_result(2, {11'h0, 2'b11, 11'h085, 8'h85});
    issue(OP_MOV_FROM_WORK, ADDR_EXTENDED, 11'h3F0, 8'h00, 1'b0, 1'b1);
    note_result(2, {11'h0, 2'b11, 11'h3F0, 8'h85});
    ld(8'h00);
    st(`ADDR_PTR_ZERO);
    ld(8'h33);
    issue(OP_MOV_TO_WORK, ADDR_DIRECT, {3'h0, `ADDR_PORT_ZERO}, 8'h00, 1'b0, 1'b0);
    note_result(0, 32'h0000_0000);
    st(`ADDR_PORT_ZERO);
    note_result(2, {11'h0, 2'b00, 11'h3F0, 8'h85});
    issue(OP_MOV_TO_WORK, ADDR_DIRECT, {3'h0, `ADDR_PORT_ONE}, 8'h00, 1'b0, 1'b0);
    r = $random(seed);
    mem_rdata <= r[7:0];
    note_result(0, {24'h0, r[7:0]});
    issue(OP_MOV_TO_WORK, ADDR_DIRECT, 11'h01F, 8'h00, 1'b0, 1'b0);
    mem_rdata <= 8'h00;
    note_result(0, 32'h0000_0000);
    ld(8'h12);
    st(`ADDR_TBL_LOW);
    st(`ADDR_TBL_HIGH);
    issue(OP_TABLE_READ, ADDR_DIRECT, 11'h030, 8'h00, 1'b0, 1'b1);
    note_result(2, {11'h0, 2'b11, 11'h030, 8'hCD});
    note_result(4, {15'h0, 1'b1, 16'h1212});
    issue(OP_MOV_TO_WORK, ADDR_DIRECT, {3'h0, `ADDR_TBL_RESULT}, 8'h00, 1'b0, 1'b0);
    note_result(0, 32'h0000_00AB);
    ld(8'h55);
    st(`ADDR_PC_LOW);
    note_result(3, {22'h0, 2'b11, 8'h55});
    issue(OP_ADD, ADDR_DIRECT, 11'h000, 8'h01, 1'b1, 1'b0);
    note_result(0, 32'h0000_0055);
    arith(1'b0, 8'h01);
    pulse(3'b000, 8'hFF, 8'h00);
    // Set both system flags, then reset in mid-run: both must clear
    pulse(3'b001, 8'hCF, 8'h10);
    pulse(3'b100, 8'hFF, 8'h20);
    @(posedge sys_clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_b <= 1'b1;
    exp_st = 8'h00;
    exp_work = 8'h00;
    note_result(1, 32'h0000_0000);
    note_result(0, 32'h0000_0000);
    repeat (3) @(posedge sys_clk);
    tally_and_finish();
  end
endmodule : mcu_indirect_addressing_and_flags_tb_top
`default_nettype wire
